// File: logic/external_bus_interface.sv
// external bus ownership arbiter and pin drive gating
// assumes a cycle engine on clk raises ext_req and reports cycle_end/last
`timescale 1ns/1ps
`default_nettype none
`include "ext_arb_defs.svh"
module external_bus_interface #(
    parameter int ADDR_W = `ARB_ADDR_W,
    parameter int DATA_W = `ARB_DATA_W,
    parameter int CTRL_W = `ARB_CTRL_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_request_n,
    output logic bus_grant_n,
    input wire logic ext_req,
    input wire logic int_req,
    input wire logic cycle_end,
    input wire logic cycle_last,
    input wire logic dummy_active,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic [DATA_W-1:0] data_in,
    input wire logic [CTRL_W-1:0] ctrl_in,
    input wire logic drive_data,
    input wire logic [`ARB_WAIT_W-1:0] wait_cfg,
    input wire logic ale_long,
    output logic ext_stall,
    output logic int_stall,
    output logic ext_start,
    output logic [`ARB_WAIT_W-1:0] wait_eff,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic [CTRL_W-1:0] ctrl_out,
    output logic ctrl_oe
);
    import ext_arb_pkg::*;

    ////////////////////////////////////////////////////////////////
    logic req_sync_n;
    logic [`ARB_WAIT_W-1:0] wait_int;

    // request pin is asynchronous to clk
    req_sync u_req_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_n(bus_request_n),
        .sync_n(req_sync_n)
    );

    wait_adjust u_wait_adjust (
        .clk(clk),
        .rst_n(rst_n),
        .wait_cfg(wait_cfg),
        .ale_long(ale_long),
        .mastering_en(1'b1),
        .wait_eff(wait_int)
    );

    ////////////////////////////////////////////////////////////////
    owner_e state_ff;
    owner_e nxt_state;
    logic pend_ff;
    logic nxt_pend;
    logic req_low;
    logic brk;

    assign req_low = !req_sync_n;
    // a break is the end of a final split cycle with no dummy-chained cycle
    assign brk = cycle_end && cycle_last && !dummy_active;

    // all ownership decisions live here; cpu and dma only see stall
    always_comb begin
        nxt_state = state_ff;
        nxt_pend = pend_ff;
        case (state_ff)
            OWN_IDLE: begin
                if (req_low) begin
                    nxt_state = GRANTED;
                end else if (ext_req) begin
                    nxt_state = OWN_BUSY;
                end
            end
            OWN_BUSY: begin
                // remember a request seen mid-cycle; grant only at the break
                if (req_low) begin
                    nxt_pend = 1'b1;
                end
                if (brk) begin
                    if (req_low || pend_ff) begin
                        nxt_state = req_low ? GRANTED : OWN_IDLE;
                    end else if (!ext_req) begin
                        nxt_state = OWN_IDLE;
                    end
                    nxt_pend = 1'b0;
                end
            end
            GRANTED: begin
                if (!req_low) begin
                    nxt_state = OWN_IDLE;
                end
            end
            default: begin
                nxt_state = OWN_IDLE;
                nxt_pend = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= OWN_IDLE;
            pend_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            pend_ff <= nxt_pend;
        end
    end

    ////////////////////////////////////////////////////////////////
    logic grant_ff;
    logic nxt_grant;
    logic ext_stall_ff;
    logic nxt_ext_stall;
    logic start_ff;
    logic nxt_start;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] nxt_addr;
    logic [DATA_W-1:0] data_ff;
    logic [DATA_W-1:0] nxt_data;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [CTRL_W-1:0] nxt_ctrl;
    logic aoe_ff;
    logic doe_ff;
    logic coe_ff;
    logic nxt_aoe;
    logic nxt_doe;
    logic nxt_coe;
    logic own_next;

    assign own_next = (nxt_state != GRANTED);

    always_comb begin
        nxt_grant = own_next ? `ARB_GRANT_IDLE : 1'b0;
        // internal requester waits on external accesses only
        nxt_ext_stall = !own_next;
        // launch from idle, or back to back at a break when still owning
        nxt_start = ext_req && own_next && (state_ff == OWN_IDLE || brk);
        // pins float the same cycle grant falls; outside cycles never reach inside
        nxt_aoe = own_next;
        nxt_coe = own_next;
        nxt_doe = own_next && drive_data;
        nxt_addr = own_next ? addr_in : addr_ff;
        nxt_data = data_in;
        nxt_ctrl = own_next ? ctrl_in : ctrl_ff;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            grant_ff <= `ARB_GRANT_IDLE;
            ext_stall_ff <= 1'b0;
            start_ff <= 1'b0;
            aoe_ff <= 1'b0;
            doe_ff <= 1'b0;
            coe_ff <= 1'b0;
            addr_ff <= '0;
            data_ff <= '0;
            ctrl_ff <= '0;
        end else begin
            grant_ff <= nxt_grant;
            ext_stall_ff <= nxt_ext_stall;
            start_ff <= nxt_start;
            aoe_ff <= nxt_aoe;
            doe_ff <= nxt_doe;
            coe_ff <= nxt_coe;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
            ctrl_ff <= nxt_ctrl;
        end
    end

    ////////////////////////////////////////////////////////////////
    // internal path is independent of ownership
    logic int_stall_ff;
    logic nxt_int_stall;

    always_comb begin
        nxt_int_stall = 1'b0 & int_req;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stall_ff <= 1'b0;
        end else begin
            int_stall_ff <= nxt_int_stall;
        end
    end

    assign bus_grant_n = grant_ff;
    assign ext_stall = ext_stall_ff;
    assign int_stall = int_stall_ff;
    assign ext_start = start_ff;
    assign wait_eff = wait_int;
    assign addr_out = addr_ff;
    assign addr_oe = aoe_ff;
    assign data_out = data_ff;
    assign data_oe = doe_ff;
    assign ctrl_out = ctrl_ff;
    assign ctrl_oe = coe_ff;
endmodule : external_bus_interface
`default_nettype wire

// File: shared/ext_arb_defs.svh
// constants for the external bus master arbiter
// assumes inclusion by bare name from any design file
`ifndef EXT_ARB_DEFS_SVH
`define EXT_ARB_DEFS_SVH

`define ARB_SYNC_STAGES 2
`define ARB_ADDR_W 24
`define ARB_DATA_W 16
`define ARB_CTRL_W 4
`define ARB_WAIT_W 3
`define ARB_WAIT_MAX 3'h7
`define ARB_ALE_LONG_EXTRA 3'h1
`define ARB_GRANT_IDLE 1'b1

`endif

// File: shared/ext_arb_pkg.sv
// types shared by the arbiter files
// assumes ext_arb_defs.svh is on the include path
package ext_arb_pkg;
    typedef enum logic [2:0] {
        OWN_IDLE = 3'b001,
        OWN_BUSY = 3'b010,
        GRANTED = 3'b100
    } owner_e;
endpackage : ext_arb_pkg

// File: logic/req_sync.sv
// two-stage synchroniser for the request pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "ext_arb_defs.svh"
module req_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pin_n,
    output logic sync_n
);
    logic [`ARB_SYNC_STAGES-1:0] stage_ff;
    logic [`ARB_SYNC_STAGES-1:0] nxt_stage;

    always_comb begin
        nxt_stage = {stage_ff[`ARB_SYNC_STAGES-2:0], pin_n};
    end

    // idle high so reset never looks like a request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage_ff <= {`ARB_SYNC_STAGES{1'b1}};
        end else begin
            stage_ff <= nxt_stage;
        end
    end

    assign sync_n = stage_ff[`ARB_SYNC_STAGES-1];
endmodule : req_sync
`default_nettype wire

// File: logic/wait_adjust.sv
// wait count adjustment for long address-latch timing
// assumes wait settings come from the chip select logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "ext_arb_defs.svh"
module wait_adjust (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [`ARB_WAIT_W-1:0] wait_cfg,
    input wire logic ale_long,
    input wire logic mastering_en,
    output logic [`ARB_WAIT_W-1:0] wait_eff
);
    logic [`ARB_WAIT_W-1:0] wait_ff;
    logic [`ARB_WAIT_W-1:0] nxt_wait;

    // saturate rather than wrap past the largest setting
    always_comb begin
        nxt_wait = wait_cfg;
        if (ale_long && mastering_en && wait_cfg != `ARB_WAIT_MAX) begin
            nxt_wait = wait_cfg + `ARB_ALE_LONG_EXTRA;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wait_ff <= '0;
        end else begin
            wait_ff <= nxt_wait;
        end
    end

    assign wait_eff = wait_ff;
endmodule : wait_adjust
`default_nettype wire

// File: tb/ebi_props.sv
// port assertions for the external bus master arbiter
// assumes a bind from the bench top, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "ext_arb_defs.svh"
module ebi_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bus_request_n,
    input wire logic bus_grant_n,
    input wire logic ext_stall,
    input wire logic int_stall,
    input wire logic addr_oe,
    input wire logic data_oe,
    input wire logic ctrl_oe,
    input wire logic [`ARB_WAIT_W-1:0] wait_cfg,
    input wire logic ale_long,
    input wire logic [`ARB_WAIT_W-1:0] wait_eff
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence off_s;
        bus_request_n [*3];
    endsequence
    sequence held_s;
        (!bus_grant_n && !bus_request_n) [*3];
    endsequence
    AST_NO_INT_STALL: assert property (!int_stall) else $error("internal stall seen");
    AST_STALL_GRANT: assert property (ext_stall == !bus_grant_n) else $error("stall off grant");
    AST_FLOAT:
    assert property (!bus_grant_n |-> !addr_oe && !data_oe && !ctrl_oe) else $error("pins driven in grant");
    AST_DRIVE_BACK: assert property ($rose(bus_grant_n) |-> addr_oe && ctrl_oe) else $error("no drive");
    AST_GRANT_CAUSE:
    assert property ($fell(bus_grant_n) |-> $past(!bus_request_n, 3)) else $error("grant too early");
    AST_RELEASE: assert property (off_s |=> bus_grant_n) else $error("grant kept");
    AST_KEEP: assert property (held_s |=> !bus_grant_n) else $error("grant dropped");
    AST_WAIT_ADJ:
    assert property (##1 wait_eff == (($past(ale_long) && $past(wait_cfg) != `ARB_WAIT_MAX)
        ? $past(wait_cfg) + `ARB_ALE_LONG_EXTRA : $past(wait_cfg))) else $error("wait count off");
endmodule : ebi_props
`default_nettype wire

// File: tb/ext_master_model.sv
// outside bus master: request, wait for grant, own, release
// assumes calls to own() are made just after a falling edge
`timescale 1ns/1ps
`default_nettype none
module ext_master_model (
    input wire logic clk,
    input wire logic bus_grant_n,
    output logic bus_request_n
);
    initial bus_request_n = 1'b1;
    task automatic own(input int n, output int lat);
        bus_request_n = 1'b0;
        lat = 0;
        while (bus_grant_n !== 1'b0 && lat < 64) begin
            @(negedge clk);
            lat++;
        end
        // short hold keeps internal traffic moving
        repeat (n) @(negedge clk);
        bus_request_n = 1'b1;
    endtask : own
endmodule : ext_master_model
`default_nettype wire

// File: tb/external_bus_interface_tb.sv
// self-checking bench for the external bus master arbiter
// assumes the master model and checker compile first
`timescale 1ns/1ps
`default_nettype none
module external_bus_interface_tb;
    logic clk, rst_n, req_n, grant_n, ext_req, int_req, c_end, c_last, dummy, drive, ale;
    logic ext_stall, int_stall, addr_oe, data_oe, ctrl_oe, start;
    logic [23:0] addr;
    logic [15:0] data;
    logic [3:0] ctrl;
    logic [2:0] wcfg, weff;
    logic [31:0] rs = 32'hE710AA6A;
    int n_mismatch = 0, tests_run = 0, cyc = 0, lat;
    external_bus_interface dut_u (.clk, .rst_n, .bus_request_n(req_n), .bus_grant_n(grant_n),
        .ext_req, .int_req, .cycle_end(c_end), .cycle_last(c_last), .dummy_active(dummy),
        .addr_in(addr), .data_in(data), .ctrl_in(ctrl), .drive_data(drive), .wait_cfg(wcfg),
        .ale_long(ale), .ext_stall, .int_stall, .ext_start(start), .wait_eff(weff), .addr_out(),
        .addr_oe, .data_out(), .data_oe, .ctrl_out(), .ctrl_oe);
    ext_master_model m_u (.clk, .bus_grant_n(grant_n), .bus_request_n(req_n));
    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [2:0] exp_wait(input logic [2:0] c, input logic a);
        return (a && c != 3'h7) ? c + 3'h1 : c;
    endfunction : exp_wait
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    initial begin
        {ext_req, int_req, c_end, c_last, dummy, drive, ale, wcfg, addr, data, ctrl} = '0;
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check("grant out of reset", grant_n, 1'b1);
        for (int i = 0; i < 20; i++) begin
            rs = lfsr(rs);
            {wcfg, ale, drive, int_req} = rs[5:0];
            {addr, ctrl} = rs[27:0];
            data = rs[31:16];
            @(negedge clk);
            check("wait count", weff, exp_wait(wcfg, ale));
            m_u.own(int'(rs[7:5]) + 1, lat);
            check("grant delay", 8'(lat), 8'h03);
            check("granted", grant_n, 1'b0);
            check("stall", ext_stall, 1'b1);
            check("int stall", int_stall, 1'b0);
            check("pins off", {addr_oe, data_oe, ctrl_oe}, 8'h00);
            repeat (2) @(negedge clk);
            check("grant held", grant_n, 1'b0);
            @(negedge clk);
            check("grant back", {grant_n, ext_stall}, 8'h02);
        end
        // break kinds: split access mid, dummy chained, real break
        ext_req = 1'b1;
        @(negedge clk);
        check("launch from idle", start, 1'b1);
        fork
            m_u.own(2, lat);
            begin
                repeat (6) @(negedge clk);
                check("mid cycle", grant_n, 1'b1);
                for (int j = 0; j < 3; j++) begin
                    {c_end, c_last, dummy} = {1'b1, j > 0, j == 1};
                    @(negedge clk);
                    {c_end, ext_req} = {1'b0, j != 2};
                    repeat (2) @(negedge clk);
                    check("break grant", grant_n, j != 2);
                end
            end
        join
        repeat (4) @(negedge clk);
        check("idle again", grant_n, 1'b1);
        give_verdict();
    end
endmodule : external_bus_interface_tb
bind external_bus_interface ebi_props p_u (.clk, .rst_n, .bus_request_n, .bus_grant_n, .ext_stall,
    .int_stall, .addr_oe, .data_oe, .ctrl_oe, .wait_cfg, .ale_long, .wait_eff);
`default_nettype wire
